// ### design/dhis_pkg.sv
package dhis_pkg;

    // Serial byte geometry
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] I2C_BITS_FULL = 4'h8;

    // Interface select encodings
    localparam logic MODE_SPI = 1'b0;
    localparam logic MODE_I2C = 1'b1;

    // Upper six bits of the own I2C address; value is arbitrary
    localparam logic [5:0] I2C_ADDR_UPPER = 6'h1E;

    // I2C control byte field holding the data/command choice
    localparam int CTRL_DC_BIT = 6;

    // I2C byte index within a frame
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_CTRL = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;

    // Level driven on the data pin while acknowledging
    localparam logic ACK_LEVEL = 1'b0;

    // Positions in the pin synchroniser vector
    localparam int P_SEL = 0;
    localparam int P_INIT = 1;
    localparam int P_CS = 2;
    localparam int P_DC = 3;
    localparam int P_SCL = 4;
    localparam int P_SDA = 5;
    localparam int P_TOG = 6;
    localparam int P_NUM = 7;

    // Idle levels of the synchronised pins
    localparam logic [6:0] PIN_RST = 7'h36;

    // System clock period, used for reasoning about crossings
    localparam int CLOCK_PERIOD_NS = 50;

    typedef enum logic [1:0] {
        I_IDLE,
        I_SHIFT,
        I_ACK,
        I_SKIP
    } i2c_state_e;

endpackage : dhis_pkg

// ### design/display_host_interface_select.sv
// Notes on behaviour
// - Select pin low gives serial, high I2C
// - Initialization pin low holds chip in init
// - Traffic accepted only while chip select low
// - Serial byte: data if pin high, else command
// - I2C: data/command pin is address bit
// - Serial: upper pin data, lower pin clock
// - I2C: upper pin SDA, lower pin SCL
module display_host_interface_select #(
    parameter logic [5:0] ADDR_UPPER = dhis_pkg::I2C_ADDR_UPPER
) (
    // System clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Host pins
    input wire logic i_interface_select,
    input wire logic i_chip_init_n,
    input wire logic i_cs_n,
    input wire logic i_data_command_sel,
    input wire logic i_serial_clock_pin,
    input wire logic i_serial_data_pin,
    output logic o_serial_data_pin_out,
    output logic o_serial_data_pin_oe,
    // Received byte stream
    output logic o_byte_valid,
    output logic [7:0] o_byte_data,
    output logic o_byte_is_data,
    // Status
    output logic o_mode_i2c,
    output logic o_init_active
);

    spi_byte_if spi_bytes ();

    // Serial mode shifter on the link clock
    spi_byte_shifter u_shifter (
        .i_serial_clock_pin(i_serial_clock_pin),
        .i_serial_data_pin(i_serial_data_pin),
        .i_data_command_sel(i_data_command_sel),
        .i_cs_n(i_cs_n),
        .i_chip_init_n(i_chip_init_n),
        .byte_out(spi_bytes.src)
    );

    // Pin synchroniser; stage one is read only by stage two
    logic [dhis_pkg::P_NUM-1:0] pins_s1_q;
    logic [dhis_pkg::P_NUM-1:0] pins_s2_q;
    logic [dhis_pkg::P_NUM-1:0] pins_raw;

    assign pins_raw = {spi_bytes.toggle, i_serial_data_pin, i_serial_clock_pin,
                       i_data_command_sel, i_cs_n, i_chip_init_n, i_interface_select};

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            pins_s1_q <= dhis_pkg::PIN_RST;
            pins_s2_q <= dhis_pkg::PIN_RST;
        end
        else
        begin
            pins_s1_q <= pins_raw;
            pins_s2_q <= pins_s1_q;
        end
    end

    logic sel_s;
    logic init_n_s;
    logic cs_n_s;
    logic sa0_s;
    logic scl_s;
    logic sda_s;
    logic tog_s;

    assign sel_s = pins_s2_q[dhis_pkg::P_SEL];
    assign init_n_s = pins_s2_q[dhis_pkg::P_INIT];
    assign cs_n_s = pins_s2_q[dhis_pkg::P_CS];
    assign sa0_s = pins_s2_q[dhis_pkg::P_DC];
    assign scl_s = pins_s2_q[dhis_pkg::P_SCL];
    assign sda_s = pins_s2_q[dhis_pkg::P_SDA];
    assign tog_s = pins_s2_q[dhis_pkg::P_TOG];

    // Block runs only outside reset and outside chip initialization
    logic run;
    assign run = i_rst_n && init_n_s;

    logic mode_q;
    logic init_q;

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            mode_q <= dhis_pkg::MODE_SPI;
            init_q <= 1'b1;
        end
        else
        begin
            mode_q <= sel_s;
            init_q <= !init_n_s;
        end
    end

    // Edge history for the I2C pins and the byte toggle
    logic scl_q;
    logic sda_q;
    logic tog_q;

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            tog_q <= 1'b0;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            tog_q <= tog_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    logic spi_evt;
    logic i2c_active;

    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign i2c_start = scl_s && scl_q && sda_q && !sda_s;
    assign i2c_stop = scl_s && scl_q && !sda_q && sda_s;
    assign spi_evt = tog_s ^ tog_q;
    assign i2c_active = run && mode_q == dhis_pkg::MODE_I2C && !cs_n_s;

    function automatic logic addr_hit(input logic [7:0] b, input logic lsb);
        addr_hit = b[7:1] == {ADDR_UPPER, lsb} && !b[0];
    endfunction : addr_hit

    // I2C receiver, oversampled on the system clock
    dhis_pkg::i2c_state_e st_q;
    logic [7:0] i2c_sr_q;
    logic [3:0] i2c_cnt_q;
    logic [1:0] idx_q;
    logic i2c_dc_q;
    logic byte_end;
    logic ack_ok;

    assign byte_end = st_q == dhis_pkg::I_SHIFT && scl_fall && i2c_cnt_q == dhis_pkg::I2C_BITS_FULL;
    assign ack_ok = idx_q != dhis_pkg::IDX_ADDR || addr_hit(i2c_sr_q, sa0_s);

    always_ff @(posedge i_clock)
    begin
        if (!i2c_active)
        begin
            st_q <= dhis_pkg::I_IDLE;
            i2c_cnt_q <= 4'h0;
            idx_q <= dhis_pkg::IDX_ADDR;
            o_serial_data_pin_oe <= 1'b0;
        end
        else if (i2c_start)
        begin
            st_q <= dhis_pkg::I_SHIFT;
            i2c_cnt_q <= 4'h0;
            idx_q <= dhis_pkg::IDX_ADDR;
            o_serial_data_pin_oe <= 1'b0;
        end
        else if (i2c_stop)
        begin
            st_q <= dhis_pkg::I_IDLE;
            o_serial_data_pin_oe <= 1'b0;
        end
        else
        begin
            case (st_q)
                dhis_pkg::I_SHIFT:
                begin
                    if (scl_rise)
                        i2c_cnt_q <= i2c_cnt_q + 4'h1;
                    if (byte_end)
                    begin
                        i2c_cnt_q <= 4'h0;
                        // Refused address holds the bus released until the next start
                        st_q <= ack_ok ? dhis_pkg::I_ACK : dhis_pkg::I_SKIP;
                        o_serial_data_pin_oe <= ack_ok;
                        if (ack_ok && idx_q != dhis_pkg::IDX_DATA)
                            idx_q <= idx_q + 2'h1;
                    end
                end
                dhis_pkg::I_ACK:
                begin
                    if (scl_fall)
                    begin
                        st_q <= dhis_pkg::I_SHIFT;
                        o_serial_data_pin_oe <= 1'b0;
                    end
                end
                dhis_pkg::I_IDLE,
                dhis_pkg::I_SKIP:
                begin
                    o_serial_data_pin_oe <= 1'b0;
                end
                default:
                begin
                    st_q <= dhis_pkg::I_IDLE;
                    o_serial_data_pin_oe <= 1'b0;
                end
            endcase
        end
    end

    // MSB first on SCL rise; SDA is sampled after its synchroniser
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            i2c_sr_q <= 8'h00;
        else if (scl_rise && st_q == dhis_pkg::I_SHIFT)
            i2c_sr_q <= {i2c_sr_q[6:0], sda_s};
    end

    // Control byte picks data or command for the rest of the frame
    always_ff @(posedge i_clock)
    begin
        if (!run)
            i2c_dc_q <= 1'b0;
        else if (i2c_active && byte_end && idx_q == dhis_pkg::IDX_CTRL)
            i2c_dc_q <= i2c_sr_q[dhis_pkg::CTRL_DC_BIT];
    end

    // Only a low level is ever driven; the pin is open drain
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            o_serial_data_pin_out <= dhis_pkg::ACK_LEVEL;
        else
            o_serial_data_pin_out <= dhis_pkg::ACK_LEVEL;
    end

    logic i2c_data_byte;
    assign i2c_data_byte = i2c_active && !i2c_start && !i2c_stop && byte_end
                           && idx_q == dhis_pkg::IDX_DATA;

    // Byte stream output, one pulse per serial byte or per I2C data byte
    always_ff @(posedge i_clock)
    begin
        if (!run)
        begin
            o_byte_valid <= 1'b0;
            o_byte_data <= 8'h00;
            o_byte_is_data <= 1'b0;
        end
        else if (spi_evt && mode_q == dhis_pkg::MODE_SPI)
        begin
            o_byte_valid <= 1'b1;
            o_byte_data <= spi_bytes.byte_data;
            o_byte_is_data <= spi_bytes.is_data;
        end
        else if (i2c_data_byte)
        begin
            o_byte_valid <= 1'b1;
            o_byte_data <= i2c_sr_q;
            o_byte_is_data <= i2c_dc_q;
        end
        else
        begin
            o_byte_valid <= 1'b0;
        end
    end

    assign o_mode_i2c = mode_q;
    assign o_init_active = init_q;

    default clocking dc_clk @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    a_mode_tracks: assert property (sel_s ##1 sel_s |-> o_mode_i2c)
        else $error("mode does not follow select pin");

    a_init_quiet: assert property (!init_n_s |=> !o_byte_valid && !o_serial_data_pin_oe)
        else $error("activity during initialization");

    a_init_flag: assert property (!init_n_s |=> o_init_active)
        else $error("init flag not raised");

    a_cs_blocks_i2c: assert property (cs_n_s |=> st_q == dhis_pkg::I_IDLE && !o_serial_data_pin_oe)
        else $error("I2C active with chip select high");

    a_spi_byte_out: assert property (spi_evt && run && mode_q == dhis_pkg::MODE_SPI
        |=> o_byte_valid && o_byte_data == $past(spi_bytes.byte_data)
            && o_byte_is_data == $past(spi_bytes.is_data))
        else $error("serial byte not forwarded with its kind");

    a_addr_ack: assert property ($rose(o_serial_data_pin_oe) && $past(idx_q) == dhis_pkg::IDX_ADDR
        |-> $past(i2c_sr_q[7:1]) == {ADDR_UPPER, $past(sa0_s)})
        else $error("acknowledged a foreign address");

    a_spi_no_drive: assert property (o_mode_i2c == dhis_pkg::MODE_SPI |-> !o_serial_data_pin_oe)
        else $error("data pin driven in serial mode");

    a_ack_release: assert property ($rose(o_serial_data_pin_oe) |-> ##[1:1000] !o_serial_data_pin_oe)
        else $error("acknowledge never released");

    a_valid_pulse: assert property (o_byte_valid |=> !o_byte_valid)
        else $error("byte valid longer than one cycle");

    c_spi_path: cover property (o_byte_valid && o_mode_i2c == dhis_pkg::MODE_SPI);
    c_i2c_data: cover property (o_byte_valid && o_mode_i2c == dhis_pkg::MODE_I2C);
    c_i2c_ack: cover property ($rose(o_serial_data_pin_oe));
    c_i2c_nak: cover property (st_q == dhis_pkg::I_SKIP);

endmodule : display_host_interface_select

// ### design/spi_byte_if.sv
interface spi_byte_if;
    logic [7:0] byte_data;
    logic is_data;
    logic toggle;

    modport src (
        output byte_data,
        output is_data,
        output toggle
    );

    modport dst (
        input byte_data,
        input is_data,
        input toggle
    );
endinterface : spi_byte_if

// ### design/spi_byte_shifter.sv
module spi_byte_shifter (
    // Link pins, clocked by the serial clock pin
    input wire logic i_serial_clock_pin,
    input wire logic i_serial_data_pin,
    input wire logic i_data_command_sel,
    input wire logic i_cs_n,
    input wire logic i_chip_init_n,
    // Completed bytes towards the system domain
    spi_byte_if.src byte_out
);

    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic toggle_q;

    // Link clock stops between frames, so chip select clears the count
    always_ff @(posedge i_serial_clock_pin or posedge i_cs_n)
    begin
        if (i_cs_n)
            bit_cnt_q <= 3'h0;
        else
            bit_cnt_q <= bit_cnt_q + 3'h1;
    end

    always_ff @(posedge i_serial_clock_pin)
    begin
        shift_q <= {shift_q[5:0], i_serial_data_pin};
    end

    // Byte and its kind stay still for a whole byte time after the toggle
    always_ff @(posedge i_serial_clock_pin or negedge i_chip_init_n)
    begin
        if (!i_chip_init_n)
        begin
            toggle_q <= 1'b0;
            byte_out.byte_data <= 8'h00;
            byte_out.is_data <= 1'b0;
        end
        else if (!i_cs_n && bit_cnt_q == dhis_pkg::BIT_LAST)
        begin
            byte_out.byte_data <= {shift_q, i_serial_data_pin};
            byte_out.is_data <= i_data_command_sel;
            toggle_q <= ~toggle_q;
        end
    end

    assign byte_out.toggle = toggle_q;

    a_eight_bits: assert property (@(posedge i_serial_clock_pin) disable iff (i_cs_n)
        $changed(toggle_q) |-> $past(bit_cnt_q) == dhis_pkg::BIT_LAST)
        else $error("byte completed off the eighth bit");

    c_spi_byte: cover property (@(posedge i_serial_clock_pin) disable iff (i_cs_n)
        $changed(toggle_q));

endmodule : spi_byte_shifter

// ### testbench/display_host_interface_select_tb.sv
module display_host_interface_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock;
    logic i_rst_n;
    logic sel, init_n, cs_n, dc, scl, sda, sda_out, sda_oe;
    logic byte_valid, is_data, mode_i2c, init_active;
    logic [7:0] byte_data;
    logic [8:0] got[$];
    int err_total;
    int checks;
    initial
    begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    display_host_interface_select u_dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_interface_select(sel),
        .i_chip_init_n(init_n), .i_cs_n(cs_n), .i_data_command_sel(dc),
        .i_serial_clock_pin(scl), .i_serial_data_pin(sda),
        .o_serial_data_pin_out(sda_out), .o_serial_data_pin_oe(sda_oe),
        .o_byte_valid(byte_valid), .o_byte_data(byte_data), .o_byte_is_data(is_data),
        .o_mode_i2c(mode_i2c), .o_init_active(init_active)
    );
    host_model u_host (
        .i_sda_oe(sda_oe), .i_sda_out(sda_out), .o_sel(sel), .o_init_n(init_n), .o_cs_n(cs_n),
        .o_dc(dc), .o_scl(scl), .o_sda(sda)
    );
    // Sampled mid-cycle, where the registered pulse has settled
    always @(negedge i_clock)
    begin
        if (byte_valid === 1'b1)
        begin
            got.push_back({is_data, byte_data});
        end
    end
    task final_report;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task chk(input string name, input logic [8:0] exp, input logic [8:0] seen);
        checks++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(negedge i_clock);
    endtask : cyc
    task expect_byte(input logic [8:0] exp);
        for (int n = 0; n < 400 && got.size() == 0; n++)
            cyc(1);
        if (got.size() == 0)
        begin
            chk("byte timeout", exp, 9'h1FF);
            final_report();
        end
        else
            chk("byte", exp, got.pop_front());
    endtask : expect_byte
    task expect_none;
        cyc(40);
        chk("stray bytes", 9'h000, 9'(got.size()));
        got.delete();
    endtask : expect_none
    task t_reset;
        chk("init during reset", 9'h001, {8'h00, init_active});
        chk("oe during reset", 9'h000, {7'h00, sda_oe, byte_valid});
        i_rst_n = 1'b1;
        cyc(6);
        chk("init held", 9'h001, {8'h00, init_active});
        u_host.set_pins(1'b0, 1'b1, 1'b0);
        cyc(6);
        chk("init done", 9'h000, {7'h00, init_active, mode_i2c});
        chk("idle drive level", 9'h000, {8'h00, sda_out});
        $display("test reset done");
    endtask : t_reset
    task t_spi;
        u_host.spi_byte(8'hA5, 1'b1, 1'b1);
        u_host.spi_byte(8'h3C, 1'b0, 1'b1);
        expect_byte({1'b1, 8'hA5});
        expect_byte({1'b0, 8'h3C});
        expect_none();
        u_host.spi_byte(8'h81, 1'b1, 1'b0);
        expect_none();
        u_host.spi_byte(8'h7E, 1'b0, 1'b1);
        expect_byte({1'b0, 8'h7E});
        $display("test serial done");
    endtask : t_spi
    task t_init;
        cyc(1);
        u_host.set_pins(1'b0, 1'b0, 1'b0);
        cyc(6);
        chk("init pin", 9'h001, {8'h00, init_active});
        u_host.spi_byte(8'h55, 1'b1, 1'b1);
        expect_none();
        u_host.set_pins(1'b0, 1'b1, 1'b0);
        cyc(6);
        u_host.spi_byte(8'hC3, 1'b1, 1'b1);
        expect_byte({1'b1, 8'hC3});
        $display("test init done");
    endtask : t_init
    task frame(input logic cs, input logic sa0, input logic [7:0] adr, input logic [7:0] ctl,
            input logic [7:0] dat, input logic ok);
        logic ack;
        cyc(1);
        u_host.set_pins(1'b1, 1'b1, sa0);
        u_host.select_chip(cs);
        u_host.i2c_edge(1'b1);
        u_host.i2c_byte(adr, ack);
        chk("address ack", {8'h00, ok}, {8'h00, ack});
        if (ok)
        begin
            u_host.i2c_byte(ctl, ack);
            u_host.i2c_byte(dat, ack);
            chk("data ack", 9'h001, {8'h00, ack});
        end
        u_host.i2c_edge(1'b0);
        if (ok)
            expect_byte({ctl[6], dat});
        else
            expect_none();
    endtask : frame
    task t_i2c;
        logic [5:0] up;
        up = dhis_pkg::I2C_ADDR_UPPER;
        cyc(1);
        u_host.set_pins(1'b1, 1'b1, 1'b0);
        cyc(6);
        chk("mode", 9'h001, {8'h00, mode_i2c});
        frame(1'b1, 1'b0, {up, 2'b00}, 8'h40, 8'h5A, 1'b1);
        frame(1'b1, 1'b1, {up, 2'b10}, 8'h00, 8'hA6, 1'b1);
        frame(1'b1, 1'b0, {up, 2'b10}, 8'h40, 8'h11, 1'b0);
        frame(1'b1, 1'b1, {up, 2'b11}, 8'h40, 8'h22, 1'b0);
        frame(1'b0, 1'b0, {up, 2'b00}, 8'h40, 8'h33, 1'b0);
        chk("released drive level", 9'h000, {7'h00, sda_out, sda_oe});
        $display("test bus mode done");
    endtask : t_i2c
    initial
    begin
        err_total = 0;
        checks = 0;
        i_rst_n = 1'b0;
        repeat (5) @(posedge i_clock);
        @(negedge i_clock);
        t_reset();
        t_spi();
        t_init();
        t_i2c();
        final_report();
    end
endmodule : display_host_interface_select_tb

// ### testbench/host_model.sv
module host_model (
    // Device answer on the data pin
    input wire logic i_sda_oe,
    input wire logic i_sda_out,
    // Pins towards the device
    output logic o_sel,
    output logic o_init_n,
    output logic o_cs_n,
    output logic o_dc,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv_q;
    // Pulled-up open-drain line in bus mode
    assign o_sda = drv_q & (~i_sda_oe | i_sda_out);
    initial
    begin
        o_sel = 1'b0;
        o_init_n = 1'b0;
        o_cs_n = 1'b1;
        o_dc = 1'b0;
        o_scl = 1'b0;
        drv_q = 1'b1;
    end
    task set_pins(input logic sel, input logic init_n, input logic dc);
        o_sel = sel;
        o_init_n = init_n;
        o_dc = dc;
        o_scl = sel;
    endtask : set_pins
    task select_chip(input logic cs);
        o_cs_n = ~cs;
    endtask : select_chip
    task spi_byte(input logic [7:0] b, input logic dc, input logic cs);
        o_cs_n = ~cs;
        o_dc = dc;
        #80;
        for (int i = 7; i >= 0; i--)
        begin
            drv_q = b[i];
            #80;
            o_scl = 1'b1;
            #80;
            o_scl = 1'b0;
        end
        // Released line shows the inverse, not the last bit
        drv_q = ~b[0];
        o_cs_n = 1'b1;
        #80;
    endtask : spi_byte
    task i2c_edge(input logic start);
        // Start is a falling data line under a high clock, stop a rising one
        drv_q = start;
        #500;
        o_scl = 1'b1;
        #500;
        drv_q = ~start;
        #500;
        if (start)
        begin
            o_scl = 1'b0;
        end
    endtask : i2c_edge
    task i2c_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            drv_q = b[i];
            #500;
            o_scl = 1'b1;
            #500;
            o_scl = 1'b0;
        end
        drv_q = 1'b1;
        #500;
        o_scl = 1'b1;
        #250;
        ack = ~o_sda;
        #250;
        o_scl = 1'b0;
    endtask : i2c_byte
endmodule : host_model
